// ---- core/acd_pkg.sv ----
// acd_pkg: shared constants of the command decoder pair
// assumes 16-bit words, bit labels octal, decimal indices here
package acd_pkg;
	localparam int W = 16;
	// ----------------------------------------
	// command word bit indices
	// ----------------------------------------
	localparam int CB_BFULL_CLR = 3;
	localparam int CB_HS_CLR    = 7;
	localparam int CB_DIAG      = 10;
	localparam int CB_PORT_DIS  = 11;
	localparam int CB_INCOMP    = 12;
	localparam int CB_RD_ACK    = 13;
	localparam int CB_WR_AVAIL  = 14;
	localparam int CB_INIT      = 15;
	localparam logic [15:0] CMD_RSVD_MASK = 16'h0377;
	// ----------------------------------------
	// status flag word bit indices
	// ----------------------------------------
	localparam int SB_BFULL  = 3;
	localparam int SB_PWRUP  = 7;
	localparam int SB_FAULT  = 10;
	localparam int SB_RD_AV  = 13;
	localparam int SB_WR_ACK = 14;
	// ----------------------------------------
	// init format word fields
	// ----------------------------------------
	localparam int IF_CNT_LO  = 0;
	localparam int IF_MODE_LO = 2;
	localparam int IF_XMIT_LO = 5;
	localparam int IF_BAUD_LO = 8;
	localparam int IF_PAR_EVN = 12;
	localparam int IF_PAR_EN  = 13;
	localparam logic [2:0] MODE_DATA   = 3'h0;
	localparam logic [2:0] MODE_REPORT = 3'h1;
	localparam logic [2:0] XM_FD_ECHO  = 3'h0;
	localparam logic [2:0] XM_FD_NOECH = 3'h1;
	localparam logic [2:0] XM_SX_READ  = 3'h2;
	localparam logic [2:0] XM_SX_WRITE = 3'h3;
	localparam logic [2:0] XM_HD_ECHO  = 3'h4;
	localparam logic [2:0] XM_HD_NOECH = 3'h5;
	localparam logic [2:0] BAUD_DEF    = 3'h0;
	// ----------------------------------------
	// strings and timing
	// ----------------------------------------
	localparam logic [9:0] LEN_MAX_DATA = 10'd62;
	localparam logic [9:0] LEN_MAX_RPT  = 10'd999;
	localparam logic [7:0] CHR_EOS      = 8'h0d;
	localparam int DIAG_CYCLES = 64;
	// ----------------------------------------
	// host register map, word indices
	// ----------------------------------------
	localparam logic [2:0] HR_CMD    = 3'h0;
	localparam logic [2:0] HR_INIT   = 3'h1;
	localparam logic [2:0] HR_DATA   = 3'h2;
	localparam logic [2:0] HR_SEND   = 3'h3;
	localparam logic [2:0] HR_STATUS = 3'h4;
	localparam logic [2:0] HR_RX     = 3'h5;
	localparam logic [2:0] HR_HSTAT  = 3'h6;
endpackage

// ---- core/acd_link_if.sv ----
// acd_link_if: block-transfer link between controller and module
// assumes both ends on one clock; words move one per cycle
`timescale 1ns/10ps
interface acd_link_if;
	logic        bt_valid;
	logic        bt_start;
	logic [15:0] bt_word;
	logic [15:0] status_flag_word;
	logic [15:0] status_count_word;
	logic [7:0]  rd_char;
	modport device (input bt_valid, bt_start, bt_word,
		output status_flag_word, status_count_word, rd_char);
	modport ctrl (output bt_valid, bt_start, bt_word,
		input status_flag_word, status_count_word, rd_char);
endinterface

// ---- core/acd_device.sv ----
// acd_device: module end, decodes command and init words
// assumes link from acd_link_if, serial side already in bytes
// Contract
// - leading two block words are commands
// - reserved command bits and word two zero
// - bit 03 clears buffer-full flag
// - bit 07 clears power-up, read, write flags
// - bit 12 runs self-test, then defaults
// - bit 13 keeps serial port disabled
// - bit 14 sends incomplete string next
// - controller acks read by matching bit 15
// - controller toggles bit 16 to send data
// - bit 17 means init words follow
// - without init, data mode and defaults
// - init bits 00-01 give word count
// - init bits 02-04 give operating mode
// - invalid mode codes fault, disable port
// - init bits 05-07 give transmission mode
// - echo modes return received characters
// - simplex pairs with one-way buffer split
// - init bits 10-12 give serial rate
// - strings 1-62 data, 1-999 report
// - bit 14 parity sense when enabled
// - after ack, present new status by toggle
// - bit 16 mismatch moves data, toggles ack
`timescale 1ns/10ps
module acd_device #(
	parameter int DIAG_N = acd_pkg::DIAG_CYCLES
) (
	// clock and reset
	input  wire logic        clock,
	input  wire logic        rst,
	// controller link
	acd_link_if.device       link,
	// serial receive side
	input  wire logic        rx_valid,
	input  wire logic [7:0]  rx_char,
	// serial transmit side
	output logic             tx_valid,
	output logic [7:0]       tx_char,
	output logic             echo_valid,
	output logic [7:0]       echo_char,
	// configuration seen by the serial engine
	output logic             port_en,
	output logic             rx_en,
	output logic             tx_en,
	output logic             half_duplex,
	output logic             report_mode,
	output logic [13:0]      baud_rate,
	output logic             parity_en,
	output logic             parity_even,
	output logic             diag_busy
);
	// ----------------------------------------
	// types and state
	// ----------------------------------------
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_CW2  = 3'b001,
		S_IW1  = 3'b010,
		S_SKIP = 3'b011,
		S_DATA = 3'b100,
		S_DIAG = 3'b101
	} acd_dst_t;

	typedef struct packed {
		acd_dst_t    st;
		logic        init;
		logic [1:0]  skip;
		logic [15:0] dcnt;
		logic        cw15;
		logic        cw16;
		logic        sw15;
		logic        sw16;
		logic        bfull;
		logic        pwrup;
		logic        fault;
		logic        pdis;
		logic        incomp;
		logic [2:0]  mode;
		logic [2:0]  xmit;
		logic [2:0]  baud;
		logic        par_en;
		logic        par_evn;
		logic [9:0]  len;
		logic        done;
		logic [7:0]  last;
		logic [15:0] cnt_word;
		logic [7:0]  rdc;
		logic        txv;
		logic [7:0]  txc;
		logic        ecv;
		logic [7:0]  ecc;
	} acd_dstate_t;

	acd_dstate_t s_reg;
	acd_dstate_t s_next;

	// ----------------------------------------
	// decode helpers
	// ----------------------------------------
	function automatic logic [13:0] baud_of(input logic [2:0] c);
		unique case (c)
			3'h0: baud_of = 14'd300;
			3'h1: baud_of = 14'd600;
			3'h2: baud_of = 14'd1200;
			3'h3: baud_of = 14'd2400;
			3'h4: baud_of = 14'd4800;
			3'h5: baud_of = 14'd9600;
			default: baud_of = 14'd110;
		endcase
	endfunction

	function automatic logic echo_of(input logic [2:0] x);
		echo_of = (x == acd_pkg::XM_FD_ECHO) ||
			(x == acd_pkg::XM_HD_ECHO);
	endfunction

	logic [15:0] w;
	logic        on;
	logic [9:0]  lmax;
	logic [2:0]  fmode;
	logic [2:0]  fxmit;
	assign w     = link.bt_word;
	assign on    = !s_reg.pdis && !s_reg.fault && s_reg.st != S_DIAG;
	assign lmax  = (s_reg.mode == acd_pkg::MODE_REPORT) ?
		acd_pkg::LEN_MAX_RPT : acd_pkg::LEN_MAX_DATA;
	assign fmode = w[acd_pkg::IF_MODE_LO +: 3];
	assign fxmit = w[acd_pkg::IF_XMIT_LO +: 3];

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		s_next = s_reg;
		s_next.txv = 1'b0;
		s_next.ecv = 1'b0;
		// write side: word sequence of a block
		if (s_reg.st == S_DIAG) begin
			s_next.dcnt = s_reg.dcnt + 16'd1;
			if (s_reg.dcnt == 16'(DIAG_N - 1)) begin
				// self-test over, back to power-up defaults
				s_next.st      = S_IDLE;
				s_next.mode    = acd_pkg::MODE_DATA;
				s_next.xmit    = acd_pkg::XM_FD_ECHO;
				s_next.baud    = acd_pkg::BAUD_DEF;
				s_next.par_en  = 1'b0;
				s_next.par_evn = 1'b0;
				s_next.fault   = 1'b0;
				s_next.pdis    = 1'b0;
				s_next.pwrup   = 1'b1;
				s_next.len     = 10'd0;
				s_next.done    = 1'b0;
			end
		end else if (link.bt_valid && link.bt_start) begin
			// first word is the command word, except while the self-test runs
			s_next.cw15 = w[acd_pkg::CB_RD_ACK];
			s_next.cw16 = w[acd_pkg::CB_WR_AVAIL];
			s_next.pdis = w[acd_pkg::CB_PORT_DIS];
			s_next.init = w[acd_pkg::CB_INIT];
			if (w[acd_pkg::CB_INCOMP])
				s_next.incomp = 1'b1;
			if (w[acd_pkg::CB_BFULL_CLR])
				s_next.bfull = 1'b0;
			if (w[acd_pkg::CB_HS_CLR]) begin
				s_next.pwrup = 1'b0;
				s_next.sw15  = 1'b0;
				s_next.sw16  = 1'b0;
			end
			if (w[acd_pkg::CB_DIAG]) begin
				s_next.st   = S_DIAG;
				s_next.dcnt = 16'd0;
			end else begin
				s_next.st = S_CW2;
			end
		end else if (link.bt_valid) begin
			unique case (s_reg.st)
				S_IDLE: begin
				end
				S_CW2: begin
					// reserved word, content ignored
					s_next.st = s_reg.init ? S_IW1 : S_DATA;
				end
				S_IW1: begin
					s_next.skip = w[acd_pkg::IF_CNT_LO +: 2];
					s_next.st   = (w[acd_pkg::IF_CNT_LO +: 2] == 2'd0) ?
						S_DATA : S_SKIP;
					if (fmode > acd_pkg::MODE_REPORT ||
						fxmit > acd_pkg::XM_HD_NOECH) begin
						s_next.fault = 1'b1;
					end else begin
						s_next.fault   = 1'b0;
						s_next.mode    = fmode;
						s_next.xmit    = fxmit;
						s_next.baud    = w[acd_pkg::IF_BAUD_LO +: 3];
						s_next.par_en  = w[acd_pkg::IF_PAR_EN];
						s_next.par_evn = w[acd_pkg::IF_PAR_EVN];
						s_next.len     = 10'd0;
						s_next.done    = 1'b0;
					end
				end
				S_SKIP: begin
					// later init words carry features not held here
					s_next.skip = s_reg.skip - 2'd1;
					if (s_reg.skip == 2'd1)
						s_next.st = S_DATA;
				end
				S_DATA: begin
					// one word moves per toggle, the rest are ignored
					if (s_reg.cw16 != s_reg.sw16) begin
						s_next.txv  = on && tx_en;
						s_next.txc  = w[7:0];
						s_next.sw16 = ~s_reg.sw16;
					end
				end
				default: s_next.st = S_IDLE;
			endcase
		end
		// read side: gather a string
		if (rx_valid && on && rx_en) begin
			if (echo_of(s_reg.xmit)) begin
				s_next.ecv = 1'b1;
				s_next.ecc = rx_char;
			end
			if (s_reg.done || s_reg.len == lmax) begin
				s_next.bfull = 1'b1; // set beats clear
			end else begin
				s_next.len  = s_reg.len + 10'd1;
				s_next.last = rx_char;
				if (rx_char == acd_pkg::CHR_EOS ||
					s_reg.len + 10'd1 == lmax)
					s_next.done = 1'b1;
			end
		end
		// present new data once the last one was acknowledged
		if (s_reg.st != S_DIAG && s_reg.sw15 == s_reg.cw15 &&
			(s_reg.done || s_reg.incomp) && s_reg.len != 10'd0 &&
			!(link.bt_valid && link.bt_start)) begin
			s_next.sw15     = ~s_reg.sw15;
			s_next.cnt_word = {6'd0, s_reg.len};
			s_next.rdc      = s_reg.last;
			s_next.len      = 10'd0;
			s_next.done     = 1'b0;
			s_next.incomp   = 1'b0;
		end
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (rst) begin
			s_reg       <= '0;
			s_reg.st    <= S_IDLE;
			s_reg.pwrup <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	always_comb begin
		link.status_flag_word = '0;
		link.status_flag_word[acd_pkg::SB_BFULL]  = s_reg.bfull;
		link.status_flag_word[acd_pkg::SB_PWRUP]  = s_reg.pwrup;
		link.status_flag_word[acd_pkg::SB_FAULT]  = s_reg.fault;
		link.status_flag_word[acd_pkg::SB_RD_AV]  = s_reg.sw15;
		link.status_flag_word[acd_pkg::SB_WR_ACK] = s_reg.sw16;
	end
	assign link.status_count_word = s_reg.cnt_word;
	assign link.rd_char           = s_reg.rdc;
	assign tx_valid    = s_reg.txv;
	assign tx_char     = s_reg.txc;
	assign echo_valid  = s_reg.ecv;
	assign echo_char   = s_reg.ecc;
	assign port_en     = on;
	assign rx_en       = s_reg.xmit != acd_pkg::XM_SX_WRITE;
	assign tx_en       = s_reg.xmit != acd_pkg::XM_SX_READ;
	assign half_duplex = s_reg.xmit[2];
	assign report_mode = s_reg.mode == acd_pkg::MODE_REPORT;
	assign baud_rate   = baud_of(s_reg.baud);
	assign parity_en   = s_reg.par_en;
	assign parity_even = s_reg.par_en && s_reg.par_evn;
	assign diag_busy   = s_reg.st == S_DIAG;
endmodule

// ---- core/acd_ctrl.sv ----
// acd_ctrl: controller end, builds write blocks and handshakes
// assumes software port on same clock, link from acd_link_if
`timescale 1ns/10ps
module acd_ctrl (
	// clock and reset
	input  wire logic        clock,
	input  wire logic        rst,
	// controller link
	acd_link_if.ctrl         link,
	// software register port
	input  wire logic [2:0]  addr,
	input  wire logic [15:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic [15:0]      rdata
);
	typedef enum logic [2:0] {
		H_IDLE = 3'b000,
		H_CW1  = 3'b001,
		H_CW2  = 3'b010,
		H_IW1  = 3'b011,
		H_DATA = 3'b100
	} acd_hst_t;

	typedef struct packed {
		acd_hst_t    st;
		logic [15:0] cmd;
		logic [15:0] iw;
		logic [15:0] dat;
		logic        dpend;
		logic        dsend;
		logic        sreq;
		logic        apend;
		logic        cw15;
		logic        cw16;
		logic        rxnew;
		logic [15:0] rxcnt;
		logic [7:0]  rxc;
		logic [15:0] rd;
		logic        bv;
		logic        bs;
		logic [15:0] bw;
	} acd_hstate_t;

	acd_hstate_t h_reg;
	acd_hstate_t h_next;

	logic [15:0] sw;
	logic [15:0] cw1;
	assign sw = link.status_flag_word;
	always_comb begin
		// reserved bits forced low
		cw1 = h_reg.cmd & ~acd_pkg::CMD_RSVD_MASK;
		cw1[acd_pkg::CB_RD_ACK]   = h_reg.cw15;
		cw1[acd_pkg::CB_WR_AVAIL] = h_reg.cw16;
	end

	always_comb begin
		h_next = h_reg;
		h_next.bv = 1'b0;
		h_next.bs = 1'b0;
		h_next.rd = '0;
		// read handshake: take data, ack by matching
		if (sw[acd_pkg::SB_RD_AV] != h_reg.cw15) begin
			h_next.cw15  = sw[acd_pkg::SB_RD_AV];
			h_next.apend = 1'b1;
			if (link.status_count_word != 16'd0) begin
				h_next.rxnew = 1'b1;
				h_next.rxcnt = link.status_count_word;
				h_next.rxc   = link.rd_char;
			end
		end
		unique case (h_reg.st)
			H_IDLE: if (h_reg.sreq || h_reg.apend) begin
				h_next.st    = H_CW1;
				h_next.sreq  = 1'b0;
				h_next.apend = 1'b0;
				// new data only after the last was acked
				if (h_reg.dpend && sw[acd_pkg::SB_WR_ACK] == h_reg.cw16)
				begin
					h_next.cw16  = ~h_reg.cw16;
					h_next.dsend = 1'b1;
					h_next.dpend = 1'b0;
				end
			end
			H_CW1: begin
				h_next.bv = 1'b1;
				h_next.bs = 1'b1;
				h_next.bw = cw1;
				h_next.st = H_CW2;
				// one-shot bits go out once per request
				h_next.cmd = h_reg.cmd & (16'h0001 <<
					acd_pkg::CB_PORT_DIS);
			end
			H_CW2: begin
				h_next.bv = 1'b1;
				h_next.bw = 16'h0000;
				// the image was cleared when word one left; use the sent word
				h_next.st = h_reg.bw[acd_pkg::CB_INIT] ? H_IW1 :
					(h_reg.dsend ? H_DATA : H_IDLE);
			end
			H_IW1: begin
				h_next.bv = 1'b1;
				h_next.bw = h_reg.iw;
				h_next.st = h_reg.dsend ? H_DATA : H_IDLE;
			end
			H_DATA: begin
				h_next.bv    = 1'b1;
				h_next.bw    = h_reg.dat;
				h_next.dsend = 1'b0;
				h_next.st    = H_IDLE;
			end
			default: h_next.st = H_IDLE;
		endcase
		if (wr) begin
			unique case (addr)
				acd_pkg::HR_CMD:  h_next.cmd = wdata;
				acd_pkg::HR_INIT: h_next.iw  = wdata;
				acd_pkg::HR_DATA: begin
					h_next.dat   = wdata;
					h_next.dpend = 1'b1;
				end
				acd_pkg::HR_SEND: h_next.sreq = 1'b1;
				default: ;
			endcase
		end
		if (rd) begin
			unique case (addr)
				acd_pkg::HR_CMD:    h_next.rd = h_reg.cmd;
				acd_pkg::HR_INIT:   h_next.rd = h_reg.iw;
				acd_pkg::HR_DATA:   h_next.rd = h_reg.dat;
				acd_pkg::HR_STATUS: h_next.rd = sw;
				acd_pkg::HR_RX: begin
					h_next.rd = {h_reg.rxcnt[7:0], h_reg.rxc};
					// a capture in the same cycle keeps the flag
					if (sw[acd_pkg::SB_RD_AV] == h_reg.cw15)
						h_next.rxnew = 1'b0;
				end
				acd_pkg::HR_HSTAT: h_next.rd = {12'd0, h_reg.rxnew,
					h_reg.dpend, h_reg.cw16, h_reg.st != H_IDLE};
				default: h_next.rd = '0;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			h_reg    <= '0;
			h_reg.st <= H_IDLE;
		end else begin
			h_reg <= h_next;
		end
	end

	assign link.bt_valid = h_reg.bv;
	assign link.bt_start = h_reg.bs;
	assign link.bt_word  = h_reg.bw;
	assign rdata         = h_reg.rd;
endmodule

// ---- verif/acd_link_checker.sv ----
// acd_link_checker: protocol assertions on the controller link
// assumes one clock, synchronous active-high reset
`timescale 1ns/10ps
module acd_link_checker (
	// clock and reset
	input wire logic        clock,
	input wire logic        rst,
	// link words and status
	input wire logic        bt_valid,
	input wire logic        bt_start,
	input wire logic [15:0] bt_word,
	input wire logic [15:0] status_flag_word,
	input wire logic [15:0] status_count_word,
	input wire logic [7:0]  rd_char
);
	// ----------------------------------------
	// last read-ack bit seen in a command word
	// ----------------------------------------
	logic ack_reg;
	always_ff @(posedge clock) begin
		if (rst)
			ack_reg <= 1'b0;
		else if (bt_valid && bt_start)
			ack_reg <= bt_word[acd_pkg::CB_RD_ACK];
	end
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	a_start_has_valid: assert property (
		bt_start |-> bt_valid)
		else $error("block start without valid");
	a_cmd_rsvd_zero: assert property (
		bt_start |-> (bt_word & acd_pkg::CMD_RSVD_MASK) == 16'h0000)
		else $error("reserved command bits set");
	a_word_two_zero: assert property (
		bt_start |=> bt_valid && !bt_start && bt_word == 16'h0000)
		else $error("second command word missing or nonzero");
	a_init_follows: assert property (
		bt_start && bt_word[acd_pkg::CB_INIT] |=> bt_valid ##1 bt_valid)
		else $error("init word does not follow");
	a_hs_clear: assert property (
		bt_start && bt_word[acd_pkg::CB_HS_CLR] |=>
		!status_flag_word[acd_pkg::SB_PWRUP] &&
		!status_flag_word[acd_pkg::SB_RD_AV] &&
		!status_flag_word[acd_pkg::SB_WR_ACK])
		else $error("handshake bits not cleared");
	a_init_fault: assert property (
		bt_start && bt_word[acd_pkg::CB_INIT] ##2
		(bt_word[4:2] > 3'h1 || bt_word[7:5] > 3'h5) |=>
		status_flag_word[acd_pkg::SB_FAULT])
		else $error("invalid init word without fault");
	a_init_ok: assert property (
		bt_start && bt_word[acd_pkg::CB_INIT] ##2
		(bt_word[4:2] <= 3'h1 && bt_word[7:5] <= 3'h5) |=>
		!status_flag_word[acd_pkg::SB_FAULT])
		else $error("valid init word left fault");
	a_rd_present: assert property (
		$rose(status_flag_word[acd_pkg::SB_RD_AV]) |->
		!ack_reg && status_count_word != 16'h0000)
		else $error("read toggle without data or against ack");
	a_wr_ack_cause: assert property (
		$rose(status_flag_word[acd_pkg::SB_WR_ACK]) |->
		$past(bt_valid) && !$past(bt_start))
		else $error("write ack without data word");
endmodule

// ---- verif/tb.sv ----
// tb: both ends joined by the link, driven from the software port
// assumes 25 MHz clock, reset held five cycles
`timescale 1ns/10ps
module tb;
	logic        clock;
	logic        rst;
	logic [2:0]  addr;
	logic [15:0] wdata;
	logic        wr;
	logic        rd;
	logic [15:0] rdata;
	logic        rx_valid;
	logic [7:0]  rx_char;
	logic        tx_valid;
	logic [7:0]  tx_char;
	logic        echo_valid;
	logic [7:0]  echo_char;
	logic        port_en;
	logic        rx_en;
	logic        tx_en;
	logic        half_duplex;
	logic        report_mode;
	logic [13:0] baud_rate;
	logic        parity_en;
	logic        parity_even;
	logic        diag_busy;
	logic [15:0] v;
	logic [7:0]  tx_last;
	logic [7:0]  echo_last;
	int          tx_cnt = 0;
	int          echo_cnt = 0;
	int          mismatches = 0;
	int          checks_done = 0;
	wire [6:0]   cfg = {report_mode, half_duplex, rx_en, tx_en,
		parity_en, parity_even, port_en};
	logic [15:0] br[8] = '{16'h012c, 16'h0258, 16'h04b0, 16'h0960,
		16'h12c0, 16'h2580, 16'h006e, 16'h006e};
	acd_link_if lk ();
	acd_ctrl acd_ctrl_i (.clock(clock), .rst(rst), .link(lk), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
	// short self-test keeps the run brief
	acd_device #(.DIAG_N(40)) acd_device_i (.clock(clock), .rst(rst),
		.link(lk), .rx_valid(rx_valid), .rx_char(rx_char),
		.tx_valid(tx_valid), .tx_char(tx_char), .echo_valid(echo_valid),
		.echo_char(echo_char), .port_en(port_en), .rx_en(rx_en),
		.tx_en(tx_en), .half_duplex(half_duplex),
		.report_mode(report_mode), .baud_rate(baud_rate),
		.parity_en(parity_en), .parity_even(parity_even),
		.diag_busy(diag_busy));
	acd_link_checker acd_link_checker_i (.clock(clock), .rst(rst),
		.bt_valid(lk.bt_valid), .bt_start(lk.bt_start),
		.bt_word(lk.bt_word), .status_flag_word(lk.status_flag_word),
		.status_count_word(lk.status_count_word), .rd_char(lk.rd_char));
	// ----------------------------------------
	// clock, monitors, timeout
	// ----------------------------------------
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	always @(posedge clock) begin
		if (tx_valid === 1'b1) begin
			tx_cnt++;
			tx_last = tx_char;
		end
		if (echo_valid === 1'b1) begin
			echo_cnt++;
			echo_last = echo_char;
		end
	end
	initial begin
		repeat (20000) @(posedge clock);
		mismatches++;
		end_sim();
	end
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task end_sim;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task chk(input string n, input logic [15:0] e, input logic [15:0] g);
		checks_done++;
		if (g !== e) begin
			$display("Error %s expected %h seen %h", n, e, g);
			mismatches++;
		end
	endtask
	task wrr(input logic [2:0] a, input logic [15:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	endtask
	task rdr(input logic [2:0] a);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1 v = rdata;
	endtask
	task rxs(input logic [7:0] c);
		@(posedge clock);
		rx_valid <= 1'b1;
		rx_char <= c;
		@(posedge clock);
		rx_valid <= 1'b0;
	endtask
	// sends one block and waits until its last word has gone
	task blk(input logic [15:0] cmd, input logic [15:0] iw);
		logic seen;
		seen = 1'b0;
		wrr(acd_pkg::HR_CMD, cmd);
		wrr(acd_pkg::HR_INIT, iw);
		wrr(acd_pkg::HR_SEND, 16'h0000);
		for (int n = 0; n < 30; n++) begin
			@(posedge clock);
			#1;
			if (lk.bt_valid === 1'b1)
				seen = 1'b1;
			else if (seen)
				break;
		end
		repeat (2) @(posedge clock);
	endtask
	task wait_rd(input logic o);
		for (int n = 0; n < 40 && lk.status_flag_word[13] === o; n++) begin
			@(posedge clock);
			#1;
		end
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_reset;
		rdr(acd_pkg::HR_STATUS);
		chk("status", 16'h0080, v);
		rdr(3'h7);
		chk("unmapped", 16'h0000, v);
		chk("cfg", 16'h0019, 16'(cfg));
		chk("baud", 16'h012c, 16'(baud_rate));
	endtask
	task t_read;
		logic s;
		int   e0;
		s = lk.status_flag_word[13];
		e0 = echo_cnt;
		rxs(8'h41);
		rxs(8'h42);
		rxs(8'h0d);
		wait_rd(s);
		chk("rd_av", 16'(!s), 16'(lk.status_flag_word[13]));
		// the end-of-string character is counted and kept as last
		chk("count", 16'h0003, lk.status_count_word);
		chk("rd_char", 16'h000d, 16'(lk.rd_char));
		chk("echo", 16'h0003, 16'(echo_cnt - e0));
		chk("echo_char", 16'h000d, 16'(echo_last));
		rdr(acd_pkg::HR_RX);
		chk("rx", 16'h030d, v);
	endtask
	task t_write;
		logic s;
		int   t0;
		for (int k = 0; k < 2; k++) begin
			s = lk.status_flag_word[14];
			t0 = tx_cnt;
			wrr(acd_pkg::HR_DATA, 16'h0041 + 16'(k));
			blk(16'h0000, 16'h0000);
			chk("tx_cnt", 16'h0001, 16'(tx_cnt - t0));
			chk("tx_char", 16'h0041 + 16'(k), 16'(tx_last));
			chk("wr_ack", 16'(!s), 16'(lk.status_flag_word[14]));
		end
	endtask
	// incomplete-string bit presents a string without its end character
	task t_incomplete;
		logic s;
		s = lk.status_flag_word[13];
		rxs(8'h5a);
		blk(16'h1000, 16'h0000);
		wait_rd(s);
		rdr(acd_pkg::HR_HSTAT);
		chk("hstat", 16'h0008, v & 16'h000e);
		chk("inc_av", 16'(!s), 16'(lk.status_flag_word[13]));
		chk("inc_char", 16'h005a, 16'(lk.rd_char));
		chk("inc_cnt", 16'h0001, lk.status_count_word);
	endtask
	// strings closing faster than the ack round trip overflow
	task t_clear;
		rxs(8'h0d);
		rxs(8'h0d);
		rxs(8'h0d);
		@(posedge clock);
		#1;
		chk("bfull", 16'h0008, lk.status_flag_word & 16'h0008);
		repeat (20) @(posedge clock);
		blk(16'h0088, 16'h0000);
		chk("hs_clr", 16'h0000, lk.status_flag_word & 16'h6088);
	endtask
	task t_bad_init;
		logic [15:0] iw[3] = '{16'h0008, 16'h00c0, 16'h0000};
		for (int k = 0; k < 3; k++) begin
			blk(16'h8000, iw[k]);
			chk("fault", (k < 2) ? 16'h0400 : 16'h0000,
				lk.status_flag_word & 16'h0400);
			chk("port_en", 16'(k == 2), 16'(port_en));
		end
	endtask
	task t_port_dis;
		blk(16'h0800, 16'h0000);
		chk("port_dis", 16'h0000, 16'(port_en));
		blk(16'h0000, 16'h0000);
		chk("port_on", 16'h0001, 16'(port_en));
	endtask
	task t_config;
		logic [2:0] x;
		logic [6:0] ef;
		int         e0;
		for (int i = 0; i < 8; i++) begin
			// simplex codes go out without a split word
			x = 3'(i % 6);
			ef = {i[0], x >= 3'h4, x != 3'h3, x != 3'h2, i[1], i[1] & i[2],
				1'b1};
			blk(16'h8000, 16'(i[1] << 13 | i[2] << 12 | i << 8 | x << 5
				| i[0] << 2 | i % 4));
			chk("cfg", 16'(ef), 16'(cfg));
			chk("baud", br[i], 16'(baud_rate));
			e0 = echo_cnt;
			rxs(8'h61);
			repeat (3) @(posedge clock);
			chk("echo", 16'(x == 3'h0 || x == 3'h4), 16'(echo_cnt - e0));
		end
	endtask
	task t_selftest;
		blk(16'h0400, 16'h0000);
		chk("busy", 16'h0001, 16'(diag_busy));
		chk("busy_port", 16'h0000, 16'(port_en));
		for (int n = 0; n < 100 && diag_busy === 1'b1; n++) begin
			@(posedge clock);
			#1;
		end
		repeat (2) @(posedge clock);
		chk("pwrup", 16'h0080, lk.status_flag_word & 16'h0080);
		chk("cfg_def", 16'h0019, 16'(cfg));
		chk("baud_def", 16'h012c, 16'(baud_rate));
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		rst = 1'b1;
		addr = 3'h0;
		wdata = 16'h0000;
		wr = 1'b0;
		rd = 1'b0;
		rx_valid = 1'b0;
		rx_char = 8'h00;
		repeat (5) @(posedge clock);
		rst <= 1'b0;
		t_reset();
		t_read();
		t_write();
		t_incomplete();
		t_clear();
		t_bad_init();
		t_port_dis();
		t_config();
		t_selftest();
		end_sim();
	end
endmodule
